// file: hdl/sac_pkg.sv
// constants and types for the converter sequencer control block
// Summary of operation
// - software clearing sample bit starts conversion
// - auto mode converts after programmed clock count
// - trigger field selects among four sources
// - enable cleared aborts conversion and sequencing
// - aborted conversion leaves result buffer untouched
// - enable clear beats simultaneous automatic start
// - conversion lasts exactly fourteen converter clocks
// - converter clock is cycle times half divider+1
// - rc select switches to internal oscillator
// - enable high active, low fully off
// - sleep without rc clock stops clocks, aborts, keeps registers
// - rc clock delays one cycle, sets done
// - sleep completion wakes or powers module off
// - idle stops module only when bit set
// - reset clears control, keeps result buffer
// - reads formatted to sixteen bits per format
// - buffer writes always right justified unsigned
// - analog pins read zero on port read
// - conversion ignores channel and direction bits
// - sampling starts acquisition, flags after sample count
package sac_pkg;

  localparam int RES_W = 12;
  localparam int BUS_W = 16;
  localparam int PIN_W = 16;
  localparam int BUF_DEPTH = 16;
  localparam int CONV_TADS = 14;
  localparam logic [3:0] CONV_LAST = 4'(CONV_TADS - 1);
  localparam int RC_WAIT_CYC = 1;

  localparam logic [2:0] TRIG_SW = 3'h0;
  localparam logic [2:0] TRIG_EXT = 3'h1;
  localparam logic [2:0] TRIG_TMR = 3'h2;
  localparam logic [2:0] TRIG_AUTO = 3'h7;

  localparam logic [1:0] FMT_INT = 2'h0;
  localparam logic [1:0] FMT_SINT = 2'h1;
  localparam logic [1:0] FMT_FRAC = 2'h2;
  localparam logic [1:0] FMT_SFRAC = 2'h3;

  typedef enum logic [1:0] {
    SAC_IDLE, SAC_SAMPLE, SAC_WAIT_RC, SAC_CONVERT
  } sac_state_e;

  typedef struct packed {
    logic converter_enable;
    logic stop_in_idle;
    logic [1:0] result_format_sel;
    logic [2:0] trigger_source_sel;
    logic auto_sample_start;
    logic [3:0] samples_per_irq;
    logic [4:0] auto_sample_clocks;
    logic rc_clock_select;
    logic [5:0] conv_clock_divider;
    logic [3:0] chan_select_group_a;
    logic [PIN_W-1:0] analog_pin_config;
  } sac_cfg_s;

  typedef struct packed {
    logic analog_power_en;
    logic sh_sample;
    logic conv_start;
    logic tad_clk;
    logic chan_connect;
    logic [3:0] mux_channel;
  } sac_core_s;

endpackage : sac_pkg

// file: hdl/sac_ctrl.sv
// sequencer, clocking, power and read-out logic of the converter
`timescale 1ns/1ps
module sac_ctrl #(
  parameter int unsigned DEPTH = sac_pkg::BUF_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire sac_pkg::sac_cfg_s cfg,
  input wire logic sample_control_bit,
  input wire logic timer_trigger,
  input wire logic ext_trigger_pin,
  input wire logic rc_osc_pin,
  input wire logic cpu_sleep,
  input wire logic cpu_idle,
  input wire logic irq_enable,
  input wire logic irq_flag_clear,
  input wire logic [sac_pkg::RES_W-1:0] conv_data,
  input wire logic buf_wr_en,
  input wire logic [3:0] buf_wr_index,
  input wire logic [sac_pkg::BUS_W-1:0] buf_wr_data,
  input wire logic [3:0] buf_rd_index,
  input wire logic [sac_pkg::PIN_W-1:0] port_pins,
  output sac_pkg::sac_core_s core,
  output logic [sac_pkg::BUS_W-1:0] rd_data,
  output logic [sac_pkg::PIN_W-1:0] port_read_data,
  output logic done_flag,
  output logic converter_irq_flag,
  output logic wake_req,
  output logic conv_done_pulse
);
  import sac_pkg::*;

  function automatic logic [BUS_W-1:0] fmt_result(
    input logic [RES_W-1:0] d,
    input logic [1:0] sel
  );
    logic [BUS_W-1:0] r;
    r = {4'h0, d};
    unique case (sel)
      FMT_INT: r = {4'h0, d};
      FMT_SINT: r = {{4{d[RES_W-1]}}, d};
      FMT_FRAC: r = {d, 4'h0};
      FMT_SFRAC: r = {~d[RES_W-1], d[RES_W-2:0], 4'h0};
    endcase
    return r;
  endfunction : fmt_result

  // pins pass two flops; only the second stage is read
  logic [1:0] ext_sync_reg;
  logic [1:0] rc_sync_reg;
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic ext_prev_reg;
  logic rc_prev_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ext_sync_reg <= 2'h0;
      rc_sync_reg <= 2'h0;
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      ext_prev_reg <= 1'b0;
      rc_prev_reg <= 1'b0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[0], ext_trigger_pin};
      rc_sync_reg <= {rc_sync_reg[0], rc_osc_pin};
      pin_meta_reg <= port_pins;
      pin_sync_reg <= pin_meta_reg;
      ext_prev_reg <= ext_sync_reg[1];
      rc_prev_reg <= rc_sync_reg[1];
    end
  end

  logic ext_rise;
  logic rc_rise;
  assign ext_rise = ext_sync_reg[1] & ~ext_prev_reg;
  assign rc_rise = rc_sync_reg[1] & ~rc_prev_reg;

  logic sample_prev_reg;
  logic sleep_prev_reg;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sample_prev_reg <= 1'b0;
      sleep_prev_reg <= 1'b0;
    end else begin
      sample_prev_reg <= sample_control_bit;
      sleep_prev_reg <= cpu_sleep;
    end
  end

  logic sample_rise;
  logic sample_fall;
  logic sleep_entry;
  assign sample_rise = sample_control_bit & ~sample_prev_reg;
  assign sample_fall = ~sample_control_bit & sample_prev_reg;
  assign sleep_entry = cpu_sleep & ~sleep_prev_reg;

  logic module_off_reg;
  logic idle_stop;
  logic clk_run;
  // sleep without the rc source kills every module clock
  assign idle_stop = cpu_idle & cfg.stop_in_idle;
  assign clk_run = cfg.converter_enable & ~module_off_reg & ~idle_stop
                   & ~(cpu_sleep & ~cfg.rc_clock_select);

  // half-cycle phase accumulator: period is (div+1)/2 cycles; a
  // divider of zero cannot tick twice per cycle so it ticks on 126 of every 127
  logic [6:0] phase_reg;
  logic [6:0] phase_sum;
  logic [6:0] tad_len;
  logic tad_tick_reg;
  assign phase_sum = phase_reg + 7'h02;
  assign tad_len = {1'b0, cfg.conv_clock_divider} + 7'h01;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= 7'h00;
      tad_tick_reg <= 1'b0;
    end else if (!clk_run) begin
      phase_reg <= 7'h00;
      tad_tick_reg <= 1'b0;
    end else if (cfg.rc_clock_select) begin
      phase_reg <= 7'h00;
      tad_tick_reg <= rc_rise;
    end else if (phase_sum >= tad_len) begin
      phase_reg <= phase_sum - tad_len;
      tad_tick_reg <= 1'b1;
    end else begin
      phase_reg <= phase_sum;
      tad_tick_reg <= 1'b0;
    end
  end

  sac_state_e state_reg;
  logic [4:0] acq_cnt_reg;
  logic [3:0] conv_cnt_reg;
  logic [3:0] smp_cnt_reg;
  logic [3:0] wr_ptr_reg;
  logic trigger;
  logic conv_end;
  logic [5:0] acq_next;

  assign acq_next = {1'b0, acq_cnt_reg} + 6'h01;
  always_comb begin
    trigger = 1'b0;
    unique case (cfg.trigger_source_sel)
      TRIG_SW: trigger = sample_fall;
      TRIG_EXT: trigger = ext_rise;
      TRIG_TMR: trigger = timer_trigger;
      // a zero clock count is illegal, it behaves as one
      TRIG_AUTO: trigger = tad_tick_reg &
                 (acq_next >= {1'b0, cfg.auto_sample_clocks});
      default: trigger = 1'b0;
    endcase
  end

  assign conv_end = (state_reg == SAC_CONVERT) & tad_tick_reg &
                    (conv_cnt_reg == CONV_LAST);

  // disable and sleep abort win over every start
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SAC_IDLE;
      acq_cnt_reg <= 5'h00;
      conv_cnt_reg <= 4'h0;
    end else if (!cfg.converter_enable ||
                 (sleep_entry && !cfg.rc_clock_select)) begin
      state_reg <= SAC_IDLE;
      acq_cnt_reg <= 5'h00;
      conv_cnt_reg <= 4'h0;
    end else if (!idle_stop && !module_off_reg) begin
      unique case (state_reg)
        SAC_IDLE: begin
          if (sample_rise) begin
            state_reg <= SAC_SAMPLE;
            acq_cnt_reg <= 5'h00;
          end
        end
        SAC_SAMPLE: begin
          if (tad_tick_reg) begin
            acq_cnt_reg <= acq_cnt_reg + 5'h01;
          end
          if (trigger) begin
            conv_cnt_reg <= 4'h0;
            state_reg <= cfg.rc_clock_select ? SAC_WAIT_RC
                                             : SAC_CONVERT;
          end
        end
        SAC_WAIT_RC: state_reg <= SAC_CONVERT;
        SAC_CONVERT: begin
          if (tad_tick_reg) begin
            conv_cnt_reg <= conv_cnt_reg + 4'h1;
          end
          if (conv_end) begin
            acq_cnt_reg <= 5'h00;
            state_reg <= cfg.auto_sample_start ? SAC_SAMPLE : SAC_IDLE;
          end
        end
      endcase
    end
  end

  logic start_now;
  assign start_now = cfg.converter_enable & ~idle_stop & ~module_off_reg &
                     ~(sleep_entry & ~cfg.rc_clock_select) &
                     (((state_reg == SAC_SAMPLE) & trigger &
                       ~cfg.rc_clock_select) |
                      (state_reg == SAC_WAIT_RC));

  logic conv_commit;
  logic irq_event;
  assign conv_commit = conv_end & cfg.converter_enable & ~idle_stop &
                       ~module_off_reg &
                       ~(sleep_entry & ~cfg.rc_clock_select);
  assign irq_event = conv_commit & (smp_cnt_reg == cfg.samples_per_irq);

  // twelve-bit result ram, never reset so a reset keeps its data
  logic [RES_W-1:0] result_buffer [DEPTH];
  always_ff @(posedge sys_clk) begin
    if (conv_commit) begin
      result_buffer[wr_ptr_reg] <= conv_data;
    end else if (buf_wr_en) begin
      result_buffer[buf_wr_index] <= buf_wr_data[RES_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      smp_cnt_reg <= 4'h0;
      wr_ptr_reg <= 4'h0;
    end else if (!cfg.converter_enable) begin
      smp_cnt_reg <= 4'h0;
      wr_ptr_reg <= 4'h0;
    end else if (irq_event) begin
      smp_cnt_reg <= 4'h0;
      wr_ptr_reg <= 4'h0;
    end else if (conv_commit) begin
      smp_cnt_reg <= smp_cnt_reg + 4'h1;
      wr_ptr_reg <= wr_ptr_reg + 4'h1;
    end
  end

  logic acq_start;
  assign acq_start = cfg.converter_enable & ~idle_stop & ~module_off_reg &
                     (state_reg == SAC_IDLE) & sample_rise;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done_flag <= 1'b0;
    end else if (irq_event) begin
      done_flag <= 1'b1;
    end else if (acq_start) begin
      done_flag <= 1'b0;
    end
  end

  // a new event in the clearing cycle keeps the flag set
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      converter_irq_flag <= 1'b0;
    end else if (irq_event) begin
      converter_irq_flag <= 1'b1;
    end else if (irq_flag_clear) begin
      converter_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wake_req <= 1'b0;
      module_off_reg <= 1'b0;
    end else if (!cpu_sleep || !cfg.converter_enable) begin
      wake_req <= 1'b0;
      module_off_reg <= 1'b0;
    end else if (irq_event) begin
      wake_req <= irq_enable;
      module_off_reg <= ~irq_enable;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      conv_done_pulse <= 1'b0;
    end else begin
      conv_done_pulse <= conv_commit;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      core <= '0;
    end else begin
      core.analog_power_en <= cfg.converter_enable & ~module_off_reg;
      core.sh_sample <= cfg.converter_enable & (state_reg == SAC_SAMPLE);
      core.conv_start <= start_now;
      core.tad_clk <= clk_run & (core.tad_clk ^ tad_tick_reg);
      // digital pins are never switched onto the sampler
      core.chan_connect <=
        ~cfg.analog_pin_config[cfg.chan_select_group_a];
      core.mux_channel <= cfg.chan_select_group_a;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= '0;
    end else begin
      rd_data <= fmt_result(result_buffer[buf_rd_index],
                            cfg.result_format_sel);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      port_read_data <= '0;
    end else begin
      port_read_data <= pin_sync_reg & cfg.analog_pin_config;
    end
  end

  abort_on_disable_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) !cfg.converter_enable |=> state_reg == SAC_IDLE)
    else $error("state not idle after enable cleared");
  no_start_disabled_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) !cfg.converter_enable |=> !core.conv_start)
    else $error("conversion started while disabled");
  conv_length_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) conv_done_pulse |-> $past(conv_cnt_reg) == CONV_LAST)
    else $error("conversion did not last fourteen clocks");
  sw_trigger_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) (state_reg == SAC_SAMPLE && sample_fall &&
     cfg.trigger_source_sel == TRIG_SW && cfg.converter_enable &&
     !cfg.rc_clock_select && !idle_stop && !module_off_reg && !cpu_sleep)
    |=> state_reg == SAC_CONVERT && core.conv_start)
    else $error("software trigger missed");
  done_clear_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) acq_start |=> !done_flag)
    else $error("done not cleared at acquisition start");
  sleep_clk_low_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) (cpu_sleep && !cfg.rc_clock_select) [*2] |-> !core.tad_clk)
    else $error("converter clock runs in sleep");
  rc_wait_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) $rose(state_reg == SAC_WAIT_RC) && cfg.converter_enable
    && !cpu_idle |=> state_reg == SAC_CONVERT)
    else $error("rc wait longer than one cycle");
  port_zero_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) 1'b1 |=> (port_read_data & ~$past(cfg.analog_pin_config)) == '0)
    else $error("analog pin read nonzero");
  int_format_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) cfg.result_format_sel == FMT_INT |=> rd_data[15:12] == 4'h0)
    else $error("integer format not zero extended");
  irq_set_a: assert property (@(posedge sys_clk)
    disable iff (!rstn) irq_event |=> converter_irq_flag && done_flag)
    else $error("flags not raised after sample count");

endmodule : sac_ctrl

// file: tb/sac_core_model.sv
// stand-in for the analog sample-hold and converter core
`timescale 1ns/1ps
module sac_core_model (
  input wire logic sys_clk,
  input wire sac_pkg::sac_core_s core,
  input wire logic [sac_pkg::RES_W-1:0] level,
  output logic [sac_pkg::RES_W-1:0] conv_data
);
  import sac_pkg::*;
  logic [RES_W-1:0] held;
  logic busy;
  initial begin
    held = 12'h000;
    busy = 1'b0;
  end
  // level is frozen at conversion start, as a hold capacitor would
  always @(posedge sys_clk) begin
    if (core.conv_start) begin
      held <= level;
      busy <= 1'b1;
    end else if (core.sh_sample || !core.analog_power_en) begin
      busy <= 1'b0;
    end
  end
  // once sampling restarts or power drops the data reads inverted, so late sampling shows
  assign conv_data = busy ? held : ~held;
endmodule : sac_core_model

// file: tb/testbench.sv
// self-checking bench for the converter sequencer control block
`timescale 1ns/1ps
module testbench;
  import sac_pkg::*;
  logic sys_clk, rstn, sample_control_bit, timer_trigger, ext_trigger_pin;
  logic rc_osc_pin, cpu_sleep, cpu_idle, irq_enable, irq_flag_clear;
  logic buf_wr_en, done_flag, converter_irq_flag, wake_req, conv_done_pulse;
  logic [3:0] buf_wr_index, buf_rd_index;
  logic [15:0] buf_wr_data, port_pins, rd_data, port_read_data, v;
  logic [11:0] conv_data, level;
  sac_cfg_s cfg;
  sac_core_s core;
  int n_fail, total_checks, at, d1, d3, a4, a7;
  logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h7};
  logic [4:0] acs [5] = '{5'h01, 5'h01, 5'h01, 5'h04, 5'h07};
  logic [15:0] fexp [4] = '{16'h08A5, 16'hF8A5, 16'h8A50, 16'h0A50};

  sac_ctrl uut (.sys_clk(sys_clk), .rstn(rstn), .cfg(cfg),
    .sample_control_bit(sample_control_bit), .timer_trigger(timer_trigger),
    .ext_trigger_pin(ext_trigger_pin), .rc_osc_pin(rc_osc_pin),
    .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle), .irq_enable(irq_enable),
    .irq_flag_clear(irq_flag_clear), .conv_data(conv_data),
    .buf_wr_en(buf_wr_en), .buf_wr_index(buf_wr_index),
    .buf_wr_data(buf_wr_data), .buf_rd_index(buf_rd_index),
    .port_pins(port_pins), .core(core), .rd_data(rd_data),
    .port_read_data(port_read_data), .done_flag(done_flag),
    .converter_irq_flag(converter_irq_flag), .wake_req(wake_req),
    .conv_done_pulse(conv_done_pulse));
  sac_core_model model (.sys_clk(sys_clk), .core(core), .level(level),
    .conv_data(conv_data));

  always #20 sys_clk = ~sys_clk;
  // rc source edges fall on falling clock edges, away from sampling
  always #120 rc_osc_pin = ~rc_osc_pin;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  function automatic bit hit(input int sel);
    case (sel)
      0: return core.conv_start === 1'b1;
      1: return conv_done_pulse === 1'b1;
      default: return core.sh_sample === 1'b1;
    endcase
  endfunction : hit

  // outputs are sampled at the falling edge, away from the driving edge
  task automatic wait_for(input int sel, input int bound, input bit must,
                          output int pos);
    pos = -1;
    for (int i = 0; i < bound; i++) begin
      @(negedge sys_clk);
      if (hit(sel)) begin
        pos = i;
        break;
      end
    end
    if (must && pos < 0) begin
      n_fail++;
      $display("Error wait %0d expected event seen none", sel);
      complete_run();
    end
  endtask : wait_for

  // sequencing fields change only with the module switched off
  task automatic acq(input logic [2:0] code, input logic [4:0] ac,
                     input logic [5:0] div, output int pos);
    @(posedge sys_clk);
    cfg.converter_enable <= 1'b0;
    cfg.trigger_source_sel <= code;
    cfg.auto_sample_clocks <= ac;
    cfg.conv_clock_divider <= div;
    @(posedge sys_clk);
    cfg.converter_enable <= 1'b1;
    tick(4);
    sample_control_bit <= 1'b1;
    wait_for(2, 50, 1'b1, pos);
    check("done flag", 16'h0000, {15'h0, done_flag});
    tick(2);
    if (code == TRIG_SW) sample_control_bit <= 1'b0;
    if (code == TRIG_TMR) timer_trigger <= 1'b1;
    if (code == TRIG_EXT) ext_trigger_pin <= 1'b1;
    @(posedge sys_clk);
    timer_trigger <= 1'b0;
    wait_for(0, 60, code != 3'h3, pos);
  endtask : acq

  task automatic rd(input logic [3:0] idx, input logic [1:0] fmt,
                    output logic [15:0] val);
    @(posedge sys_clk);
    buf_rd_index <= idx;
    cfg.result_format_sel <= fmt;
    tick(2);
    @(negedge sys_clk);
    val = rd_data;
  endtask : rd

  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    cfg = '0;
    cfg.analog_pin_config = 16'h00F0;
    {sample_control_bit, timer_trigger, ext_trigger_pin, rc_osc_pin} = 4'h0;
    {cpu_sleep, cpu_idle, irq_enable, irq_flag_clear, buf_wr_en} = 5'h00;
    {buf_wr_index, buf_rd_index, buf_wr_data} = 24'h000000;
    port_pins = 16'hFFFF;
    level = 12'h5A3;
    tick(8);
    rstn <= 1'b1;
    @(negedge sys_clk);
    check("core", 16'h0000, {7'h0, core});
    check("irq flag", 16'h0000, {15'h0, converter_irq_flag});
    tick(4);
    check("port read", 16'h00F0, port_read_data);
    acq(TRIG_SW, 5'h01, 6'h01, at);
    wait_for(1, 200, 1'b1, d1);
    check("done flag", 16'h0001, {15'h0, done_flag});
    check("irq flag", 16'h0001, {15'h0, converter_irq_flag});
    @(posedge sys_clk);
    irq_flag_clear <= 1'b1;
    @(posedge sys_clk);
    irq_flag_clear <= 1'b0;
    @(negedge sys_clk);
    check("irq flag", 16'h0000, {15'h0, converter_irq_flag});
    acq(TRIG_SW, 5'h01, 6'h03, at);
    wait_for(1, 200, 1'b1, d3);
    check("conversion span", 16'd14, 16'(d3 - d1));
    rd(4'h0, FMT_INT, v);
    check("result", 16'h05A3, v);
    @(posedge sys_clk);
    buf_wr_en <= 1'b1;
    buf_wr_index <= 4'h5;
    buf_wr_data <= 16'hF8A5;
    @(posedge sys_clk);
    buf_wr_en <= 1'b0;
    for (int f = 0; f < 4; f++) begin
      rd(4'h5, 2'(f), v);
      check("formatted read", fexp[f], v);
    end
    level <= 12'h3C3;
    for (int k = 0; k < 2; k++) begin
      acq(TRIG_SW, 5'h01, 6'h03, at);
      tick(3);
      if (k == 0) cfg.converter_enable <= 1'b0;
      else cpu_sleep <= 1'b1;
      wait_for(1, 40, 1'b0, at);
      check("aborted done", 16'hFFFF, 16'(at));
      check("tad clock", 16'h0000, {15'h0, core.tad_clk});
      rd(4'h0, FMT_INT, v);
      check("kept result", 16'h05A3, v);
      @(posedge sys_clk);
      cpu_sleep <= 1'b0;
    end
    for (int t = 0; t < 5; t++) begin
      acq(codes[t], acs[t], 6'h01, at);
      if (codes[t] == 3'h3) begin
        check("reserved trigger", 16'hFFFF, 16'(at));
      end else begin
        if (t == 3) a4 = at;
        if (t == 4) a7 = at;
        wait_for(1, 200, 1'b1, d1);
      end
      @(posedge sys_clk);
      sample_control_bit <= 1'b0;
      ext_trigger_pin <= 1'b0;
    end
    check("auto sample span", 16'd3, 16'(a7 - a4));
    @(posedge sys_clk);
    cfg.rc_clock_select <= 1'b1;
    irq_enable <= 1'b1;
    acq(TRIG_SW, 5'h01, 6'h01, at);
    @(posedge sys_clk);
    cpu_sleep <= 1'b1;
    wait_for(1, 200, 1'b1, d1);
    check("wake request", 16'h0001, {15'h0, wake_req});
    check("rc done flag", 16'h0001, {15'h0, done_flag});
    @(posedge sys_clk);
    cpu_sleep <= 1'b0;
    cfg.rc_clock_select <= 1'b0;
    irq_enable <= 1'b0;
    @(posedge sys_clk);
    rstn <= 1'b0;
    tick(2);
    rstn <= 1'b1;
    @(negedge sys_clk);
    check("done flag", 16'h0000, {15'h0, done_flag});
    rd(4'h5, FMT_INT, v);
    check("buffer kept", 16'h08A5, v);
    complete_run();
  end
endmodule : testbench
